/* rtl/pwr_mode_pkg.sv */
// Constants, types and state names for the power reduction mode controller
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package pwr_mode_pkg;
   localparam int          NUM_PINS            = 8;
   localparam logic [15:0] ADDR_WAKE_SELECT    = 16'hF1C0;
   localparam logic [15:0] ADDR_SYS_CONFIG     = 16'hF1C2;
   localparam logic [15:0] ADDR_STATUS         = 16'hF1C4;
   localparam logic [15:0] WAKE_SELECT_RESET   = 16'h0000;
   localparam logic [15:0] SYS_CONFIG_RESET    = 16'h0000;
   localparam int          WAKE_CFG_BIT        = 0;
   localparam logic [1:0]  SEL_OFF             = 2'h0;
   localparam logic [1:0]  SEL_HIGH            = 2'h1;
   localparam logic [1:0]  SEL_LOW             = 2'h2;
   localparam logic [1:0]  SEL_ANY             = 2'h3;

   typedef enum logic [2:0] {ST_RUN, ST_DRAIN, ST_IDLE, ST_PD, ST_WAKE} pwr_state_e;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_s;
endpackage : pwr_mode_pkg

/* rtl/power_reduction_mode_control.sv */
// Power reduction mode controller: Idle and Power Down entry, exit and wake
`timescale 1ns/1ps
module power_reduction_mode_control
(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_arst_n,
   input  wire pwr_mode_pkg::bus_req_s i_bus,
   output logic [15:0]                o_rdata,
   input  wire logic                  i_idle_instr,
   input  wire logic                  i_deep_sleep_instr,
   input  wire logic                  i_end_init_instr,
   input  wire logic                  i_return_from_irq_instr,
   input  wire logic                  i_instr_done,
   input  wire logic                  i_bus_busy,
   input  wire logic                  i_ready_enable,
   input  wire logic                  i_ready_polarity,
   input  wire logic                  i_ready_pin,
   input  wire logic                  i_irq_request,
   input  wire logic                  i_periph_event_xfer_active,
   input  wire logic                  i_periph_event_xfer_fail,
   input  wire logic                  i_nmi_pin,
   input  wire logic [7:0]            i_fast_ext_irq_pin,
   input  wire logic                  i_delay_below_threshold,
   output logic                       o_cpu_clk_en,
   output logic                       o_periph_clk_en,
   output logic                       o_osc_pll_en,
   output logic                       o_watchdog_hold,
   output logic                       o_rpd_pulldown_en,
   output logic                       o_rpd_pullup_en,
   output logic                       o_idle_resume_pend,
   output logic [7:0]                 o_fast_irq_req
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   // Every asynchronous pin passes two flops; only stage two is read.
   localparam int SYNC_W = 11;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [7:0]        pin_lvl;
   logic              nmi_lvl;
   logic              ready_lvl;
   logic              delay_low;

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= {i_delay_below_threshold, i_ready_pin, i_nmi_pin, i_fast_ext_irq_pin};
         sync_b <= sync_a;
      end
   end

   assign pin_lvl   = sync_b[7:0];
   assign nmi_lvl   = sync_b[8];
   assign ready_lvl = sync_b[9];
   assign delay_low = sync_b[10];

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [15:0] wake_select;
   logic [15:0] sys_config;
   logic        cfg_locked;
   logic        wake_cfg;
   logic        ready_last;
   logic        ready_acc;
   logic        busy_d;
   pwr_mode_pkg::pwr_state_e state;
   pwr_mode_pkg::pwr_state_e next_state;
   logic        kind_deep;

   assign wake_cfg = sys_config[pwr_mode_pkg::WAKE_CFG_BIT];

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         cfg_locked <= 1'b0;
      else if (i_end_init_instr)
         cfg_locked <= 1'b1;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         wake_select <= pwr_mode_pkg::WAKE_SELECT_RESET;
         sys_config  <= pwr_mode_pkg::SYS_CONFIG_RESET;
      end
      else if (i_bus.wr)
      begin
         if (i_bus.addr == pwr_mode_pkg::ADDR_WAKE_SELECT)
            wake_select <= i_bus.wdata;
         if (i_bus.addr == pwr_mode_pkg::ADDR_SYS_CONFIG && !cfg_locked)
            sys_config <= {15'h0000, i_bus.wdata[pwr_mode_pkg::WAKE_CFG_BIT]};
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_rdata <= 16'h0000;
      else if (!i_bus.rd)
         o_rdata <= 16'h0000;
      else
      begin
         case (i_bus.addr)
            pwr_mode_pkg::ADDR_WAKE_SELECT: o_rdata <= wake_select;
            pwr_mode_pkg::ADDR_SYS_CONFIG:  o_rdata <= sys_config;
            pwr_mode_pkg::ADDR_STATUS:
               o_rdata <= {10'h000, cfg_locked, ready_last,
                           state == pwr_mode_pkg::ST_WAKE,
                           state == pwr_mode_pkg::ST_PD,
                           state == pwr_mode_pkg::ST_IDLE,
                           state == pwr_mode_pkg::ST_DRAIN};
            default:                        o_rdata <= 16'h0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Ready tracking over the last bus access
   // ------------------------------------------------------------------
   logic ready_match;
   logic ready_seen;
   assign ready_match = (ready_lvl == i_ready_polarity);
   // An access ending at this very edge is the most recent one; its result
   // is not yet in ready_last, so take it straight from the accumulator.
   assign ready_seen  = (busy_d && !i_bus_busy) ? ready_acc : ready_last;

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         busy_d     <= 1'b0;
         ready_acc  <= 1'b0;
         ready_last <= 1'b1;
      end
      else
      begin
         busy_d <= i_bus_busy;
         if (i_bus_busy && !busy_d)
            ready_acc <= ready_match;
         else if (i_bus_busy)
            ready_acc <= ready_acc | ready_match;
         if (!i_bus_busy && busy_d)
            ready_last <= ready_acc;
      end
   end

   // ------------------------------------------------------------------
   // Per-pin select decode, edges and wake levels
   // ------------------------------------------------------------------
   // One decode for both entry test and wake test: a pin is "active" when
   // it sits at its wake level, compared to the level it had at entry.
   function automatic logic pin_active(input logic [1:0] sel,
                                       input logic       lvl,
                                       input logic       ref_lvl);
      case (sel)
         pwr_mode_pkg::SEL_HIGH: pin_active = lvl;
         pwr_mode_pkg::SEL_LOW:  pin_active = !lvl;
         pwr_mode_pkg::SEL_ANY:  pin_active = lvl != ref_lvl;
         default:                pin_active = 1'b0;
      endcase
   endfunction : pin_active

   logic [7:0] prev_lvl;
   logic [7:0] entry_lvl;
   logic [7:0] entry_block;
   logic [7:0] wake_hit;
   logic [7:0] edge_req;

   genvar gi;
   generate
      for (gi = 0; gi < pwr_mode_pkg::NUM_PINS; gi++)
      begin : g_pin
         logic [1:0] sel;
         assign sel = wake_select[2*gi+1:2*gi];
         assign entry_block[gi] = pin_active(sel, pin_lvl[gi], pin_lvl[gi]);
         // Level sensitive; the interrupt enable bits play no part here
         assign wake_hit[gi] = pin_active(sel, pin_lvl[gi], entry_lvl[gi]);
         assign edge_req[gi] =
            ((sel == pwr_mode_pkg::SEL_HIGH) && pin_lvl[gi] && !prev_lvl[gi]) ||
            ((sel == pwr_mode_pkg::SEL_LOW) && !pin_lvl[gi] && prev_lvl[gi]) ||
            ((sel == pwr_mode_pkg::SEL_ANY) && (pin_lvl[gi] != prev_lvl[gi]));
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         prev_lvl <= 8'h00;
      else
         prev_lvl <= pin_lvl;
   end

   // ------------------------------------------------------------------
   // Mode sequencer
   // ------------------------------------------------------------------
   logic entry_ok;
   logic drain_done;
   assign drain_done = (state == pwr_mode_pkg::ST_DRAIN) && !i_bus_busy;
   assign entry_ok   = !(i_ready_enable && !ready_seen);

   always_comb
   begin
      next_state = state;
      case (state)
         pwr_mode_pkg::ST_RUN:
            if (i_idle_instr || i_deep_sleep_instr)
               next_state = pwr_mode_pkg::ST_DRAIN;
         pwr_mode_pkg::ST_DRAIN:
            if (!i_bus_busy)
            begin
               if (!entry_ok)
                  next_state = pwr_mode_pkg::ST_RUN;
               else if (!kind_deep)
                  next_state = pwr_mode_pkg::ST_IDLE;
               else if (!wake_cfg)
                  next_state = nmi_lvl ? pwr_mode_pkg::ST_RUN : pwr_mode_pkg::ST_PD;
               else
                  next_state = (|entry_block) ? pwr_mode_pkg::ST_RUN : pwr_mode_pkg::ST_PD;
            end
         pwr_mode_pkg::ST_IDLE:
            // A transfer in flight keeps Idle; only its failure or an interrupt request ends it
            if (i_irq_request || i_periph_event_xfer_fail)
               next_state = pwr_mode_pkg::ST_RUN;
         pwr_mode_pkg::ST_PD:
            // With config 0 only the asynchronous reset leaves this state
            if (wake_cfg && (|wake_hit))
               next_state = pwr_mode_pkg::ST_WAKE;
         pwr_mode_pkg::ST_WAKE:
            if (delay_low)
               next_state = pwr_mode_pkg::ST_RUN;
         default:
            next_state = pwr_mode_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         state <= pwr_mode_pkg::ST_RUN;
      else
         state <= next_state;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         kind_deep <= 1'b0;
      else if (state == pwr_mode_pkg::ST_RUN && (i_idle_instr || i_deep_sleep_instr))
         kind_deep <= i_deep_sleep_instr;
   end

   // Entry levels let select 11 wake on any change from them
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         entry_lvl <= 8'h00;
      else if (drain_done)
         entry_lvl <= pin_lvl;
   end

   // ------------------------------------------------------------------
   // Clock, oscillator and delay pin controls
   // ------------------------------------------------------------------
   logic in_pd;
   assign in_pd = (state == pwr_mode_pkg::ST_PD) || (state == pwr_mode_pkg::ST_WAKE);

   assign o_cpu_clk_en      = (state != pwr_mode_pkg::ST_IDLE) && !in_pd;
   assign o_periph_clk_en   = !in_pd;
   assign o_osc_pll_en      = state != pwr_mode_pkg::ST_PD;
   assign o_watchdog_hold   = in_pd;
   assign o_rpd_pulldown_en = state == pwr_mode_pkg::ST_WAKE;
   // Pull-up off while discharging, else it fights the weak pull-down
   assign o_rpd_pullup_en   = wake_cfg && (state != pwr_mode_pkg::ST_WAKE);

   // ------------------------------------------------------------------
   // Resume tracking and interrupt requests
   // ------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_idle_resume_pend <= 1'b0;
      else if (state == pwr_mode_pkg::ST_IDLE && next_state == pwr_mode_pkg::ST_RUN)
         o_idle_resume_pend <= 1'b1;
      else if (i_return_from_irq_instr)
         o_idle_resume_pend <= 1'b0;
   end

   // Wake requests wait for one completed instruction so the one after
   // the deep-sleep instruction runs before the service call.
   logic [7:0] wake_cap;
   logic [7:0] wake_pend;

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         wake_cap <= 8'h00;
      else if (state == pwr_mode_pkg::ST_PD && next_state == pwr_mode_pkg::ST_WAKE)
         wake_cap <= wake_hit;
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         wake_pend <= 8'h00;
      else if (state == pwr_mode_pkg::ST_WAKE && next_state == pwr_mode_pkg::ST_RUN)
         wake_pend <= wake_cap;
      else if (i_instr_done)
         wake_pend <= 8'h00;
   end

   // Request pulses feed the flag logic; servicing depends on its enable
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_fast_irq_req <= 8'h00;
      else
         o_fast_irq_req <= (in_pd ? 8'h00 : edge_req) |
                           (i_instr_done ? wake_pend : 8'h00);
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_pd_to_wake;
      state == pwr_mode_pkg::ST_PD ##1 state == pwr_mode_pkg::ST_WAKE;
   endsequence

   sequence s_deep_cfg0_nmi_high;
      drain_done && kind_deep && entry_ok && !wake_cfg && nmi_lvl;
   endsequence

   AST_IDLE_CLOCKS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state == pwr_mode_pkg::ST_IDLE |-> !o_cpu_clk_en && o_periph_clk_en)
      else $error("Idle clocks wrong");

   AST_PD_STOP: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state == pwr_mode_pkg::ST_PD |-> !o_cpu_clk_en && !o_periph_clk_en && !o_osc_pll_en && o_watchdog_hold)
      else $error("Power Down did not stop clocks");

   AST_DRAIN_WAIT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state == pwr_mode_pkg::ST_DRAIN && i_bus_busy |=> state == pwr_mode_pkg::ST_DRAIN)
      else $error("Sleep entered during bus transaction");

   AST_READY_REFUSE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      drain_done && i_ready_enable && !ready_seen |=> state == pwr_mode_pkg::ST_RUN)
      else $error("Sleep entered without ready");

   AST_IDLE_EXIT: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state == pwr_mode_pkg::ST_IDLE && i_irq_request |=> state == pwr_mode_pkg::ST_RUN ##1 o_idle_resume_pend)
      else $error("Interrupt did not end Idle");

   AST_XFER_KEEPS_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state == pwr_mode_pkg::ST_IDLE && !i_irq_request && !i_periph_event_xfer_fail
      |=> state == pwr_mode_pkg::ST_IDLE)
      else $error("Idle left without cause");

   AST_XFER_NO_WAKE: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state == pwr_mode_pkg::ST_IDLE && i_periph_event_xfer_active
      && !i_irq_request && !i_periph_event_xfer_fail |=> !o_cpu_clk_en)
      else $error("Event transfer woke the CPU");

   AST_NMI_NOP: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_deep_cfg0_nmi_high |=> state == pwr_mode_pkg::ST_RUN)
      else $error("Deep sleep taken with NMI high");

   AST_CFG0_STAYS: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      state == pwr_mode_pkg::ST_PD && !wake_cfg |=> state == pwr_mode_pkg::ST_PD)
      else $error("Protected Power Down left without reset");

   AST_CFG_LOCK: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      cfg_locked |=> $stable(sys_config))
      else $error("Locked configuration changed");

   AST_WAKE_SEQ: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      s_pd_to_wake |-> o_osc_pll_en && o_rpd_pulldown_en && !o_cpu_clk_en)
      else $error("Wake did not restart oscillator");

endmodule : power_reduction_mode_control

/* tb/wake_pin_model.sv */
// Far-side model: NMI pin, fast interrupt pins and the RC delay comparator
`timescale 1ns/1ps
module wake_pin_model
#(
   parameter int DELAY_CYC = 12
)
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_nmi_low,
   input  wire logic [7:0] i_pin_base,
   input  wire logic       i_wake,
   input  wire logic [2:0] i_wake_idx,
   input  wire logic       i_pulldown_en,
   input  wire logic       i_pullup_en,
   output logic            o_nmi_pin,
   output logic [7:0]      o_fast_ext_irq_pin,
   output logic            o_delay_below_threshold
);
   logic [7:0] flip = 8'h00;
   logic [2:0] hold = 3'h0;
   int         charge_cnt = 0;

   // ---------------------------------------------------------------
   // Wake pulse on one pin, held 4 cycles (100 ns) to stay above 40 ns
   // ---------------------------------------------------------------
   always @(posedge i_sys_clk)
   begin
      if (i_wake)
      begin
         flip <= 8'h01 << i_wake_idx;
         hold <= 3'h4;
      end
      else if (hold != 3'h0)
      begin
         hold <= hold - 3'h1;
         if (hold == 3'h1)
            flip <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Capacitor discharges while pulled down, recharges on the pull-up
   // ---------------------------------------------------------------
   always @(posedge i_sys_clk)
   begin
      if (i_pulldown_en)
         charge_cnt <= (charge_cnt < DELAY_CYC) ? charge_cnt + 1 : charge_cnt;
      else if (i_pullup_en)
         charge_cnt <= 0;
   end

   assign o_delay_below_threshold = (charge_cnt >= DELAY_CYC);
   assign o_fast_ext_irq_pin      = i_pin_base ^ flip;
   assign o_nmi_pin               = !i_nmi_low;
endmodule : wake_pin_model

/* tb/power_reduction_mode_control_bench.sv */
// Self-checking bench for the power reduction mode controller
`timescale 1ns/1ps
module power_reduction_mode_control_bench;
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } reg_row_s;

   localparam logic [4:0] P_IDLE = 5'h01;
   localparam logic [4:0] P_DEEP = 5'h02;
   localparam logic [4:0] P_END_INIT_INSTR = 5'h04;
   localparam logic [4:0] P_RETURN_FROM_IRQ_INSTR = 5'h08;
   localparam logic [4:0] P_DONE = 5'h10;

   logic                   clk;
   logic                   arst_n;
   pwr_mode_pkg::bus_req_s bus;
   logic [15:0]            rdata;
   logic [15:0]            v;
   logic [4:0]             pulses;
   logic                   busy, rdy_en, rdy_pol, rdy_pin, irq, xfer_act, xfer_fail;
   logic                   nmi_low, wake;
   logic [2:0]             wake_idx;
   logic [7:0]             pin_base;
   logic                   nmi_pin, below;
   logic [7:0]             pins, fast_req;
   logic                   cpu_en, per_en, osc_en, wdg, pd_en, pu_en, resume;
   int                     n_mismatch, compares, cycles, cnt;
   reg_row_s               rows [7];

   power_reduction_mode_control u_dut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_bus(bus), .o_rdata(rdata),
      .i_idle_instr(pulses[0]), .i_deep_sleep_instr(pulses[1]), .i_end_init_instr(pulses[2]),
      .i_return_from_irq_instr(pulses[3]), .i_instr_done(pulses[4]), .i_bus_busy(busy),
      .i_ready_enable(rdy_en), .i_ready_polarity(rdy_pol), .i_ready_pin(rdy_pin), .i_irq_request(irq),
      .i_periph_event_xfer_active(xfer_act), .i_periph_event_xfer_fail(xfer_fail), .i_nmi_pin(nmi_pin),
      .i_fast_ext_irq_pin(pins), .i_delay_below_threshold(below), .o_cpu_clk_en(cpu_en),
      .o_periph_clk_en(per_en), .o_osc_pll_en(osc_en), .o_watchdog_hold(wdg), .o_rpd_pulldown_en(pd_en),
      .o_rpd_pullup_en(pu_en), .o_idle_resume_pend(resume), .o_fast_irq_req(fast_req));

   wake_pin_model u_pins (.i_sys_clk(clk), .i_nmi_low(nmi_low), .i_pin_base(pin_base), .i_wake(wake),
      .i_wake_idx(wake_idx), .i_pulldown_en(pd_en), .i_pullup_en(pu_en), .o_nmi_pin(nmi_pin),
      .o_fast_ext_irq_pin(pins), .o_delay_below_threshold(below));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic summarize;
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic pulse(input logic [4:0] p);
      @(posedge clk);
      pulses <= p;
      @(posedge clk);
      pulses <= 5'h00;
   endtask : pulse

   task automatic wait_cpu(input logic lvl);
      for (int i = 0; i < 40 && cpu_en !== lvl; i++)
         tick(1);
   endtask : wait_cpu

   task automatic leave_idle;
      @(posedge clk);
      irq <= 1'b1;
      wait_cpu(1'b1);
      @(posedge clk);
      irq <= 1'b0;
      pulse(P_RETURN_FROM_IRQ_INSTR);
   endtask : leave_idle

   // Ready is synchronised, so it is set up before the access and held through it
   task automatic burst;
      @(posedge clk);
      busy <= 1'b1;
      repeat (4) @(posedge clk);
      busy <= 1'b0;
      tick(2);
   endtask : burst

   task automatic do_reset;
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      tick(3);
   endtask : do_reset

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {arst_n, busy, rdy_en, rdy_pol, rdy_pin, irq, xfer_act, xfer_fail, nmi_low, wake} = '0;
      bus = '0; pulses = 5'h00; wake_idx = 3'h0; pin_base = 8'h00;
      n_mismatch = 0; compares = 0; cycles = 0;
      rows = '{'{pwr_mode_pkg::ADDR_WAKE_SELECT, 1'b0, 16'h0000, pwr_mode_pkg::WAKE_SELECT_RESET},
               '{pwr_mode_pkg::ADDR_SYS_CONFIG, 1'b0, 16'h0000, pwr_mode_pkg::SYS_CONFIG_RESET},
               '{pwr_mode_pkg::ADDR_STATUS, 1'b0, 16'h0000, 16'h0010},
               '{pwr_mode_pkg::ADDR_WAKE_SELECT, 1'b1, 16'hA5C3, 16'hA5C3},
               '{pwr_mode_pkg::ADDR_SYS_CONFIG, 1'b1, 16'hFFFE, 16'h0000},
               '{16'hF1C6, 1'b1, 16'hFFFF, 16'h0000},
               '{pwr_mode_pkg::ADDR_STATUS, 1'b1, 16'hFFFF, 16'h0010}};
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      tick(3);
      foreach (rows[i])
      begin
         if (rows[i].wr)
            wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, v);
         chk(v, rows[i].exp);
      end
      // Idle entry, clocks, exit and resume marker
      pulse(P_IDLE);
      tick(2);
      chk(cpu_en, 1'b0);
      chk(per_en, 1'b1);
      @(posedge clk);
      irq <= 1'b1;
      wait_cpu(1'b1);
      chk(cpu_en, 1'b1);
      tick(1);
      chk(resume, 1'b1);
      @(posedge clk);
      irq <= 1'b0;
      pulse(P_RETURN_FROM_IRQ_INSTR);
      tick(1);
      chk(resume, 1'b0);
      // Event transfer keeps Idle, a failed one ends it
      pulse(P_IDLE);
      @(posedge clk);
      xfer_act <= 1'b1;
      tick(5);
      chk(cpu_en, 1'b0);
      @(posedge clk);
      xfer_act <= 1'b0;
      xfer_fail <= 1'b1;
      wait_cpu(1'b1);
      chk(cpu_en, 1'b1);
      @(posedge clk);
      xfer_fail <= 1'b0;
      pulse(P_RETURN_FROM_IRQ_INSTR);
      // Pending bus access drains first
      @(posedge clk);
      busy <= 1'b1;
      pulse(P_IDLE);
      tick(6);
      chk(cpu_en, 1'b1);
      @(posedge clk);
      busy <= 1'b0;
      tick(3);
      chk(cpu_en, 1'b0);
      leave_idle();
      // Ready enabled but missed refuses sleep; matched allows it
      @(posedge clk);
      {rdy_en, rdy_pol, rdy_pin} <= 3'b110;
      burst();
      pulse(P_IDLE);
      tick(6);
      chk(cpu_en, 1'b1);
      @(posedge clk);
      rdy_pin <= 1'b1;
      tick(3);
      burst();
      pulse(P_IDLE);
      tick(3);
      chk(cpu_en, 1'b0);
      leave_idle();
      // Access missing ready that ends at the drain edge still refuses
      @(posedge clk);
      rdy_pin <= 1'b0;
      tick(3);
      @(posedge clk);
      busy <= 1'b1;
      pulse(P_IDLE);
      @(posedge clk);
      busy <= 1'b0;
      tick(4);
      chk(cpu_en, 1'b1);
      @(posedge clk);
      rdy_en <= 1'b0;
      // Protected power down: NMI gate, frozen clocks, reset-only exit
      wr(pwr_mode_pkg::ADDR_WAKE_SELECT, 16'h0001);
      pulse(P_DEEP);
      tick(6);
      chk({cpu_en, osc_en}, 2'b11);
      @(posedge clk);
      nmi_low <= 1'b1;
      tick(3);
      pulse(P_DEEP);
      tick(3);
      chk({cpu_en, per_en}, 2'b00);
      chk(osc_en, 1'b0);
      chk(wdg, 1'b1);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      tick(20);
      chk({cpu_en, osc_en}, 2'b00);
      do_reset();
      chk({cpu_en, osc_en, wdg}, 3'b110);
      @(posedge clk);
      nmi_low <= 1'b0;
      // Interruptible power down across select encodings 01, 10 and 11 on pin 0
      wr(pwr_mode_pkg::ADDR_SYS_CONFIG, 16'h0001);
      tick(1);
      chk(pu_en, 1'b1);
      wr(pwr_mode_pkg::ADDR_WAKE_SELECT, 16'h0001);
      @(posedge clk);
      pin_base <= 8'h01;
      tick(3);
      pulse(P_DEEP);
      tick(4);
      chk(cpu_en, 1'b1);
      for (int k = 1; k < 4; k++)
      begin
         wr(pwr_mode_pkg::ADDR_WAKE_SELECT, 16'(k));
         @(posedge clk);
         pin_base <= (k == 2) ? 8'h03 : 8'h02;
         tick(3);
         pulse(P_DEEP);
         tick(3);
         chk(osc_en, 1'b0);
         @(posedge clk);
         wake <= 1'b1;
         @(posedge clk);
         wake <= 1'b0;
         for (int i = 0; i < 10 && osc_en !== 1'b1; i++)
            tick(1);
         chk({osc_en, pd_en, cpu_en}, 3'b110);
         wait_cpu(1'b1);
         chk({cpu_en, pd_en}, 2'b10);
         tick(3);
         chk(fast_req[0], 1'b0);
         pulse(P_DONE);
         #1 chk(fast_req, 8'h01);
      end
      // Edge interrupts in normal running: rising, falling, either
      wr(pwr_mode_pkg::ADDR_WAKE_SELECT, 16'h0390);
      @(posedge clk);
      pin_base <= 8'h08;
      tick(4);
      for (int k = 2; k < 5; k++)
      begin
         @(posedge clk);
         wake <= 1'b1;
         wake_idx <= 3'(k);
         @(posedge clk);
         wake <= 1'b0;
         cnt = 0;
         repeat (12)
         begin
            tick(1);
            cnt += fast_req[k];
         end
         chk(16'(cnt), (k == 4) ? 16'h0002 : 16'h0001);
      end
      // Configuration locked after end of initialisation
      pulse(P_END_INIT_INSTR);
      wr(pwr_mode_pkg::ADDR_SYS_CONFIG, 16'h0000);
      rd(pwr_mode_pkg::ADDR_SYS_CONFIG, v);
      chk(v, 16'h0001);
      summarize();
   end
endmodule : power_reduction_mode_control_bench
